// ### verilog/askpr_pkg.sv
// package: constants for the ask shaping power ramp index block
package askpr_pkg;
  localparam int          TABLE_DEPTH    = 8;
  localparam int          INDEX_W        = 3;
  localparam int          LEVEL_W        = 8;
  localparam int          TICKS_PER_SYM  = 8;
  localparam logic [2:0]  INDEX_ZERO     = 3'h0;
  localparam logic [2:0]  LIMIT_RESET    = 3'h0;
  localparam logic [7:0]  LEVEL_RESET    = 8'h00;
  localparam logic [7:0]  ENTRY0_RESET   = 8'hc6;
endpackage : askpr_pkg

// ### verilog/askpr_table.sv
// memory: eight-entry power level table with registered read
`timescale 1ns/1ps
`default_nettype none
module askpr_table
  import askpr_pkg::*;
#(
  parameter int DEPTH = TABLE_DEPTH,
  parameter int AW    = INDEX_W,
  parameter int DW    = LEVEL_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_index,
  input  wire logic [DW-1:0] wr_level,
  input  wire logic          sleep_enter,
  input  wire logic [AW-1:0] rd_index,
  output var  logic [DW-1:0] rd_level
);
  initial begin
    if (DEPTH != (1 << AW)) $error("table depth must equal two to the index width");
  end

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] mem_at_index;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= (i == 0) ? ENTRY0_RESET : LEVEL_RESET;
      end
    end else if (sleep_enter) begin
      // entry 0 survives sleep, others read back cleared
      for (int i = 1; i < DEPTH; i++) begin
        mem[i] <= LEVEL_RESET;
      end
    end else if (wr_en) begin
      mem[wr_index] <= wr_level;
    end
  end

  // ----------------------------------------
  // registered read
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_level <= LEVEL_RESET;
    end else begin
      rd_level <= mem[rd_index];
    end
  end

  // observation point for the lookup check in the core
  always_comb begin
    mem_at_index = mem[rd_index];
  end

  a_entry0_kept: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_enter |=> mem[0] == $past(mem[0]))
    else $error("entry 0 changed on sleep");

  a_sleep_clears: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_enter |=> mem[DEPTH-1] == LEVEL_RESET)
    else $error("upper entry kept across sleep");
endmodule : askpr_table
`default_nettype wire

// ### verilog/askpr_core.sv
// top: saturating shaping counter indexing the power level table
`timescale 1ns/1ps
`default_nettype none
module askpr_core
  import askpr_pkg::*;
#(
  parameter int AW = INDEX_W,
  parameter int DW = LEVEL_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          tx_active,
  input  wire logic          shape_tick,
  input  wire logic          tx_bit,
  input  wire logic [AW-1:0] power_index_limit,
  input  wire logic          table_wr_en,
  input  wire logic [AW-1:0] table_wr_index,
  input  wire logic [DW-1:0] table_wr_level,
  input  wire logic          sleep_enter,
  output var  logic [DW-1:0] amp_level_code,
  output var  logic [AW-1:0] shape_index
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the index width is fixed by the three-bit limit field
  initial begin
    if (AW != INDEX_W) $error("index width must be three");
    if (DW < 1) $error("level width must be positive");
    if (DW != LEVEL_W) $error("level width must match the reset constants");
  end

  logic [DW-1:0] table_level;
  logic [AW-1:0] next_index;
  logic          tick_taken;
  logic          below_limit;
  logic          at_zero;
  logic          step_up;
  logic          step_down;
  logic          clamp_top;

  // ----------------------------------------
  // step decode
  // ----------------------------------------
  // ticks outside a frame are dropped; the index is parked at zero there
  always_comb begin
    tick_taken  = tx_active && shape_tick;
    below_limit = shape_index < power_index_limit;
    at_zero     = shape_index == INDEX_ZERO;
    step_up     = tick_taken && tx_bit && below_limit;
    step_down   = tick_taken && !tx_bit && !at_zero;
    clamp_top   = tick_taken && tx_bit && !below_limit;
  end

  // ----------------------------------------
  // shaping counter
  // ----------------------------------------
  always_comb begin
    next_index = shape_index;
    if (!tx_active) begin
      next_index = INDEX_ZERO;
    end else if (step_up) begin
      next_index = shape_index + AW'(1);
    end else if (clamp_top) begin
      // also pulls the index down if the limit was lowered mid-frame
      next_index = power_index_limit;
    end else if (step_down) begin
      next_index = shape_index - AW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shape_index <= INDEX_ZERO;
    end else begin
      shape_index <= next_index;
    end
  end

  // ----------------------------------------
  // table lookup
  // ----------------------------------------
  // read and output are both registered: the code lags the index by two
  askpr_table #(
    .DEPTH (1 << AW),
    .AW    (AW),
    .DW    (DW)
  ) u_table (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .wr_en       (table_wr_en),
    .wr_index    (table_wr_index),
    .wr_level    (table_wr_level),
    .sleep_enter (sleep_enter),
    .rd_index    (shape_index),
    .rd_level    (table_level)
  );

  // ----------------------------------------
  // amplifier code register
  // ----------------------------------------
  // a flop here keeps the amplifier setting free of decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      amp_level_code <= LEVEL_RESET;
    end else begin
      amp_level_code <= table_level;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_count_up: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && shape_index < power_index_limit ##1 tx_active
      |-> shape_index == $past(shape_index) + 3'h1)
    else $error("counter failed to step up");

  a_count_down: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit && shape_index != 3'h0 ##1 tx_active
      |-> shape_index == $past(shape_index) - 3'h1)
    else $error("counter failed to step down");

  a_hold_no_tick: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && !shape_tick ##1 tx_active |-> $stable(shape_index))
    else $error("counter moved without a tick");

  a_sat_top: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && shape_index == power_index_limit
      |=> shape_index == $past(power_index_limit))
    else $error("counter passed the limit");

  a_sat_zero: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit && shape_index == 3'h0 |=> shape_index == 3'h0)
    else $error("counter wrapped below zero");

  a_limit_zero: assert property (@(posedge sys_clk) disable iff (rst)
    power_index_limit == 3'h0 && shape_index == 3'h0 |=> shape_index == 3'h0)
    else $error("ramp active with zero limit");

  a_lookup_path: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1
      |=> ##1 amp_level_code == $past(u_table.mem_at_index, 2))
    else $error("amplifier code does not follow index");

  a_start_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !tx_active |=> shape_index == 3'h0)
    else $error("counter not zero outside transmission");

  // ----------------------------------------
  // checks: stepping, saturation and frame start and end
  // ----------------------------------------
  a_index_bound: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick
      |=> shape_index <= $past(power_index_limit) || shape_index < $past(shape_index))
    else $error("counter left above the limit");

  a_clamp_above: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && shape_index > power_index_limit
      |=> shape_index == $past(power_index_limit))
    else $error("counter not clamped to a lowered limit");

  a_down_never_up: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit
      |=> shape_index <= $past(shape_index))
    else $error("counter rose on a zero bit");

  a_up_never_down: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && shape_index <= power_index_limit
      |=> shape_index >= $past(shape_index))
    else $error("counter fell on a one bit");

  a_single_step: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && shape_index <= power_index_limit
      |=> shape_index == $past(shape_index) || shape_index == $past(shape_index) + 3'h1
        || shape_index == $past(shape_index) - 3'h1)
    else $error("counter moved more than one step per tick");

  a_zero_limit_up: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && power_index_limit == 3'h0
      |=> shape_index == 3'h0)
    else $error("counter ramped with a zero limit");

  a_zero_limit_down: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit && power_index_limit == 3'h0 && shape_index == 3'h0
      |=> shape_index == 3'h0)
    else $error("counter left entry 0 with a zero limit");

  a_no_wrap_up: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit
      |=> shape_index != 3'h0 || $past(power_index_limit) == 3'h0)
    else $error("counter wrapped past the top");

  a_no_wrap_down: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit
      |=> shape_index != 3'h7)
    else $error("counter wrapped past the bottom");

  a_up_from_zero: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && tx_bit && shape_index == 3'h0 && power_index_limit != 3'h0
      |=> shape_index == 3'h1)
    else $error("counter did not leave zero on a one bit");

  a_down_to_zero: assert property (@(posedge sys_clk) disable iff (rst)
    tx_active && shape_tick && !tx_bit && shape_index == 3'h1
      |=> shape_index == 3'h0)
    else $error("counter did not reach zero on a zero bit");

  a_rise_from_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(tx_active)
      |-> shape_index == 3'h0)
    else $error("transmission began away from zero");

  a_frame_end_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(tx_active)
      |=> shape_index == 3'h0)
    else $error("counter kept its value after the frame");
endmodule : askpr_core
`default_nettype wire

// ### testbench/askpr_src_model.sv
// model of the bit source: ticks and transmitted bits
`timescale 1ns/1ps
`default_nettype none
module askpr_src_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic bit_val,
  output var  logic shape_tick,
  output var  logic tx_bit
);
  // tick every other cycle; the bit is garbage between ticks on purpose
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shape_tick <= 1'b0;
      tx_bit     <= 1'b0;
    end else begin
      shape_tick <= run & ~shape_tick;
      tx_bit     <= (run & ~shape_tick) ? bit_val : ~tx_bit;
    end
  end
endmodule : askpr_src_model
`default_nettype wire

// ### testbench/ask_shaping_power_ramp_index_bench.sv
// bench: ramps, limits, sleep and restart of the shaping counter
`timescale 1ns/1ps
`default_nettype none
module ask_shaping_power_ramp_index_bench;
  import askpr_pkg::*;
  logic sys_clk = 0, rst = 1, tx_active = 0, run = 0, bit_val = 0, tick, tx_bit;
  logic [2:0] limit = 3'h0, wr_index = 3'h0, shape_index;
  logic [7:0] wr_level = 8'h00, code, tbl [8];
  logic wr_en = 0, sleep_enter = 0;
  int num_errors = 0, compares = 0, cyc = 0;
  askpr_src_model src (.sys_clk(sys_clk), .rst(rst), .run(run), .bit_val(bit_val),
    .shape_tick(tick), .tx_bit(tx_bit));
  askpr_core dut (.sys_clk(sys_clk), .rst(rst), .tx_active(tx_active), .shape_tick(tick),
    .tx_bit(tx_bit), .power_index_limit(limit), .table_wr_en(wr_en),
    .table_wr_index(wr_index), .table_wr_level(wr_level), .sleep_enter(sleep_enter),
    .amp_level_code(code), .shape_index(shape_index));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (exp !== got) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // n ticks, then settle so the output path catches up
  task automatic ramp(logic [2:0] lim, logic b, int n, logic [2:0] idx);
    limit <= lim;
    bit_val <= b;
    run <= 1'b1;
    repeat (n) @(posedge sys_clk iff tick);
    run <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("shape_index", {5'h0, idx}, {5'h0, shape_index});
    chk("amp_level_code", tbl[idx], code);
  endtask : ramp
  task automatic t_main;
    for (int i = 0; i < 8; i++) begin
      tbl[i] = (i == 0) ? 8'h3f : 8'h30 + 8'(i);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      wr_index <= 3'(i);
      wr_level <= tbl[i];
    end
    @(posedge sys_clk);
    wr_en <= 1'b0;
    tx_active <= 1'b1;
    ramp(3'h7, 1'b1, 10, 3'h7);
    ramp(3'h7, 1'b0, 3, 3'h4);
    ramp(3'h7, 1'b0, 10, 3'h0);
    ramp(3'h3, 1'b1, 5, 3'h3);
    ramp(3'h0, 1'b1, 2, 3'h0);
    ramp(3'h1, 1'b1, 3, 3'h1);
    $display("ramp tests done");
  endtask : t_main
  task automatic t_restart;
    ramp(3'h7, 1'b1, 4, 3'h5);
    tx_active <= 1'b0;
    repeat (2) @(posedge sys_clk);
    tx_active <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("restart index", 8'h00, {5'h0, shape_index});
    ramp(3'h7, 1'b1, 2, 3'h2);
    $display("restart test done");
  endtask : t_restart
  task automatic t_sleep;
    @(posedge sys_clk);
    sleep_enter <= 1'b1;
    @(posedge sys_clk);
    sleep_enter <= 1'b0;
    for (int i = 1; i < 8; i++) tbl[i] = 8'h00;
    ramp(3'h7, 1'b1, 10, 3'h7);
    ramp(3'h0, 1'b0, 10, 3'h0);
    $display("sleep test done");
  endtask : t_sleep
  task automatic summarize;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("reset code", 8'h00, code);
    repeat (2) @(posedge sys_clk);
    chk("reset entry0", ENTRY0_RESET, code);
    t_main();
    t_restart();
    t_sleep();
    summarize();
  end
endmodule : ask_shaping_power_ramp_index_bench
`default_nettype wire
